// ---- hdl/sdst_spi_target.sv ----
// SPI target of a chained switch diagnostic block: three-byte packets,
// chain id pass-through and the auto-clear mask register.
// Assumes core_clk runs well above the serial clock (320 ns period in use).
`timescale 1ns/1ns

// How it works
// RULE1: packet is control, address, data bytes
// RULE2: control byte: broadcast, read, reserved, reversed id
// RULE3: master sends id zero when unchained
// RULE4: chain id decremented on way out
// RULE5: second byte addresses, third byte carries data
// RULE6: drive serial output only for read data
// RULE7: sample bits on rising serial clock edges
// RULE8: select rise after eight bits advances bytes
// RULE9: short or long bytes may misalign sequencing
// RULE10: clock edge while deselected restarts packet
// RULE11: master may resync with deselected clock
// RULE12: abandoned write leaves register unchanged
// RULE13: over-clocked data byte may corrupt register
// RULE14: master should reissue aborted writes
// RULE15: auto-clear mask at seven, resets ones
// RULE16: mask bits map to diagnostic reports
// RULE17: unmapped read returns zero
// RULE18: unmapped write updates nothing
// RULE19: id zero addresses, broadcast writes all
// RULE20: forward packet bits unchanged except id
// RULE21: reserved mask bit ignores writes
// RULE22: addresses eight and nine are unmapped
module sdst_spi_target (
  // Core clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Serial pins from the master
  input  wire logic sclkPin,
  input  wire logic selectN,
  input  wire logic mosiPin,
  // Serial output, three-state by enable
  output logic      misoOut,
  output logic      misoOe,
  // Chain pass-through to the next part
  output logic      chainDataOut,
  // Mask towards the diagnostic logic
  output logic [7:0] autoClearMask
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [2:0]        sclkSync;   // [0] first stage only feeds [1]
    logic [2:0]        selSync;
    logic [2:0]        mosiSync;
    logic              sclkF;      // Filtered levels
    logic              selF;
    logic              mosiF;
    logic [3:0]        bitCnt;     // Bits taken in this byte
    logic [7:0]        rxShift;    // Incoming byte
    logic              pend;       // Token waiting for the buffer
    logic [8:0]        pendTok;
    logic              borrow;     // Serial decrement of the chain id
    sdst_pkg::sdst_pkt_t pkt;      // Packet position
    logic              cool;       // Sequencer rests one cycle per token
    logic              isRead;
    logic              bcast;
    logic              targeted;
    logic [7:0]        addr;
    logic              readArmed;  // Read data owned for the data byte
    logic [7:0]        txShift;
    logic              misoO;
    logic              misoE;
    logic              chainO;
    logic [7:0]        mask;
  } sdst_core_st_t;

  sdst_core_st_t st_r;
  sdst_core_st_t st_nxt;

  // Decoded pin events
  logic sclkNew, selNew, mosiNew;
  logic sclkRise, sclkFall, selRise, selFall;
  logic cidPos;
  // Buffer handshake
  logic                      bufInReady;
  logic                      bufOutValid;
  logic [sdst_pkg::TOK_W-1:0] bufOutData;
  logic                      pop;
  logic [7:0]                tokByte;
  logic                      tokMark;
  logic                      maskWrite;

  // ************************************************************
  // Pin filtering: a change counts once stages two and three agree
  // ************************************************************
  assign sclkNew  = (st_r.sclkSync[1] == st_r.sclkSync[2]) ? st_r.sclkSync[2] : st_r.sclkF;
  assign selNew   = (st_r.selSync[1]  == st_r.selSync[2])  ? st_r.selSync[2]  : st_r.selF;
  assign mosiNew  = (st_r.mosiSync[1] == st_r.mosiSync[2]) ? st_r.mosiSync[2] : st_r.mosiF;
  assign sclkRise = sclkNew & ~st_r.sclkF;
  assign sclkFall = ~sclkNew & st_r.sclkF;
  assign selRise  = selNew & ~st_r.selF;   // Deselect, end of byte
  assign selFall  = ~selNew & st_r.selF;   // Select, start of byte

  // Id bits are bits four to zero of the control byte, first taken LSB first
  assign cidPos = (st_r.pkt == sdst_pkg::SDST_PKT_CTRL) && !st_r.selF &&
                  (st_r.bitCnt >= sdst_pkg::CID_FIRST) && (st_r.bitCnt < sdst_pkg::BYTE_BITS);

  // Sequencer drains at most every other cycle, so the buffer can fill
  assign pop       = bufOutValid & ~st_r.cool;
  assign tokMark   = bufOutData[8];
  assign tokByte   = bufOutData[7:0];
  assign maskWrite = pop && !tokMark && (st_r.pkt == sdst_pkg::SDST_PKT_DATA) && !st_r.isRead &&
                     (st_r.targeted || st_r.bcast) && (st_r.addr == sdst_pkg::ADDR_AUTOCLR);

  // ************************************************************
  // Token buffer between byte capture and packet sequencer
  // ************************************************************
  sdst_pair_buf #(
    .W     (sdst_pkg::TOK_W),
    .DEPTH (sdst_pkg::BUF_DEPTH)
  ) u_buf (
    .core_clk (core_clk),
    .reset    (reset),
    .inValid  (st_r.pend),
    .inData   (st_r.pendTok),
    .inReady  (bufInReady),
    .outValid (bufOutValid),
    .outData  (bufOutData),
    .outReady (~st_r.cool)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    // Synchronisers and filtered levels
    st_nxt.sclkSync = {st_r.sclkSync[1:0], sclkPin};
    st_nxt.selSync  = {st_r.selSync[1:0], selectN};
    st_nxt.mosiSync = {st_r.mosiSync[1:0], mosiPin};
    st_nxt.sclkF    = sclkNew;
    st_nxt.selF     = selNew;
    st_nxt.mosiF    = mosiNew;

    // A waiting token leaves once the buffer takes it; capture runs on, and a newer token overwrites it
    if (st_r.pend && bufInReady) begin
      st_nxt.pend = 1'b0;
    end

    // Byte capture on rising serial clock edges
    if (sclkRise) begin
      if (st_r.selF) begin
        // Edge while deselected: restart via an in-order marker token [RULE10]
        st_nxt.bitCnt  = '0;
        st_nxt.pend    = 1'b1;
        st_nxt.pendTok = {1'b1, 8'h00};
      end else begin
        st_nxt.rxShift = {st_r.rxShift[6:0], mosiNew};  // [RULE7]
        if (st_r.bitCnt != sdst_pkg::BIT_SAT) begin
          st_nxt.bitCnt = st_r.bitCnt + 4'h1;
        end
        // Borrow ripples from id LSB upward as bits go by [RULE4]
        if (cidPos) begin
          st_nxt.borrow = st_r.borrow & ~mosiNew;
        end
      end
    end

    // Byte end: a full byte advances; a short one is dropped [RULE8] [RULE9]
    // Extra edges keep only the last eight bits taken [RULE13]
    if (selRise) begin
      if (st_nxt.bitCnt >= sdst_pkg::BYTE_BITS) begin
        st_nxt.pend    = 1'b1;
        st_nxt.pendTok = {1'b0, st_nxt.rxShift};
      end
      st_nxt.bitCnt = '0;  // [RULE12]
    end
    if (selFall) begin
      st_nxt.bitCnt = '0;
      st_nxt.borrow = 1'b1;
    end

    // Chain output: copy of the input, id field decremented [RULE20] [RULE4]
    // Held while the serial clock is high inside a byte: count and borrow have moved on,
    // so recomputing then would put the next bit's fix-up on the current bit [RULE20]
    if (st_r.selF || !st_r.sclkF) begin
      st_nxt.chainO = cidPos ? (mosiNew ^ st_r.borrow) : mosiNew;
    end

    // Packet sequencer
    st_nxt.cool = pop;
    if (pop) begin
      if (tokMark) begin
        st_nxt.pkt       = sdst_pkg::SDST_PKT_CTRL;
        st_nxt.readArmed = 1'b0;
      end else begin
        unique case (st_r.pkt)
          sdst_pkg::SDST_PKT_CTRL: begin
            // Decode the control byte; reserved bit is not checked [RULE2]
            st_nxt.isRead   = tokByte[sdst_pkg::CTL_READ_BIT];
            st_nxt.bcast    = tokByte[sdst_pkg::CTL_BROADCAST_BIT];
            st_nxt.targeted = (tokByte[sdst_pkg::CID_W-1:0] == sdst_pkg::CID_SELF);  // [RULE19]
            st_nxt.pkt      = sdst_pkg::SDST_PKT_ADDR;  // [RULE1]
          end
          sdst_pkg::SDST_PKT_ADDR: begin
            // Address byte; broadcast plays no part in a read [RULE5]
            st_nxt.addr = tokByte;
            st_nxt.pkt  = sdst_pkg::SDST_PKT_DATA;
            if (st_r.isRead && st_r.targeted) begin
              st_nxt.readArmed = 1'b1;
              // Only the mask answers; 8 and 9 and the rest read zero [RULE17] [RULE22]
              st_nxt.txShift = (tokByte == sdst_pkg::ADDR_AUTOCLR) ? st_r.mask : sdst_pkg::READ_UNMAPPED;
            end
          end
          sdst_pkg::SDST_PKT_DATA: begin
            // Write lands only on the mask address [RULE18] [RULE19]
            if (maskWrite) begin
              // Reserved bit keeps its reset value [RULE21] [RULE16]
              st_nxt.mask = (tokByte & ~sdst_pkg::AUTOCLR_RESERVED_SLOT_A) | sdst_pkg::AUTOCLR_RESERVED_SLOT_A;  // [RULE15]
            end
            st_nxt.readArmed = 1'b0;
            st_nxt.pkt       = sdst_pkg::SDST_PKT_CTRL;
          end
        endcase
      end
    end

    // Read data leaves MSB first, next bit after each falling edge [RULE6]
    if (st_r.readArmed && !selNew && sclkFall) begin
      st_nxt.txShift = {st_r.txShift[6:0], 1'b0};
    end
    st_nxt.misoO = st_nxt.txShift[7];
    st_nxt.misoE = st_r.readArmed && !selNew && (st_r.pkt == sdst_pkg::SDST_PKT_DATA);  // [RULE6]
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r          <= '0;
      st_r.sclkSync <= 3'h0;
      st_r.selSync  <= 3'h7;   // Idle as deselected
      st_r.selF     <= 1'b1;
      st_r.borrow   <= 1'b1;
      st_r.pkt      <= sdst_pkg::SDST_PKT_CTRL;
      st_r.mask     <= sdst_pkg::AUTOCLR_RESET;  // [RULE15]
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign misoOut       = st_r.misoO;
  assign misoOe        = st_r.misoE;
  assign chainDataOut  = st_r.chainO;
  assign autoClearMask = st_r.mask;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_oe_read_only;
    misoOe |-> (st_r.readArmed && st_r.isRead && st_r.targeted && !st_r.selF);
  endproperty
  a_oe_read_only: assert property (p_oe_read_only) else $error("miso driven outside read data"); // [RULE6]

  property p_reserved_slot_a_bit;
    autoClearMask[sdst_pkg::AUTOCLR_RESERVED_BIT];
  endproperty
  a_reserved_slot_a_bit: assert property (p_reserved_slot_a_bit) else $error("reserved mask bit lost"); // [RULE21]

  property p_unmapped_write;
    (pop && !tokMark && st_r.pkt == sdst_pkg::SDST_PKT_DATA && st_r.addr != sdst_pkg::ADDR_AUTOCLR)
      |=> $stable(autoClearMask);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("mask changed by other address"); // [RULE18]

  property p_mask_write;
    maskWrite |=> (autoClearMask == ($past(tokByte) | sdst_pkg::AUTOCLR_RESERVED_SLOT_A));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write not applied"); // [RULE19]

  property p_resync;
    (sclkRise && st_r.selF) |=> (st_r.pend && st_r.pendTok[8] && st_r.bitCnt == 4'h0);
  endproperty
  a_resync: assert property (p_resync) else $error("resync marker missing"); // [RULE10]

  property p_unmapped_read;
    (pop && !tokMark && st_r.pkt == sdst_pkg::SDST_PKT_ADDR && st_r.isRead && st_r.targeted &&
     tokByte != sdst_pkg::ADDR_AUTOCLR) |=> (st_r.txShift == sdst_pkg::READ_UNMAPPED);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // [RULE17]

  property p_full_byte;
    (selRise && !sclkRise && st_r.bitCnt >= sdst_pkg::BYTE_BITS) |=> (st_r.pend && !st_r.pendTok[8]);
  endproperty
  a_full_byte: assert property (p_full_byte) else $error("full byte not queued"); // [RULE8]

  property p_short_byte;
    (selRise && !sclkRise && st_r.bitCnt < sdst_pkg::BYTE_BITS && !st_r.pend) |=> !st_r.pend;
  endproperty
  a_short_byte: assert property (p_short_byte) else $error("short byte queued"); // [RULE12]

  property p_pass_through;
    (st_r.selF && !selFall) |=> (chainDataOut == $past(mosiNew));
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("chain output differs"); // [RULE20]

  property p_order;
    (pop && !tokMark && st_r.pkt == sdst_pkg::SDST_PKT_ADDR) |=> (st_r.pkt == sdst_pkg::SDST_PKT_DATA);
  endproperty
  a_order: assert property (p_order) else $error("address not followed by data"); // [RULE1]

  c_read: cover property (misoOe ##1 !misoOe);
  c_bcast: cover property (maskWrite && st_r.bcast);
  c_resync: cover property (sclkRise && st_r.selF);
  c_full_buf: cover property (!bufInReady);

endmodule : sdst_spi_target

// ---- include/sdst_pkg.sv ----
// Constants shared by the diagnostic SPI target and its token buffer.
// Assumes the pins are sampled by a faster core clock than the serial clock.
package sdst_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADDR_AUTOCLR    = 8'h07;  // Auto-clear mask
  localparam logic [7:0] ADDR_RESERVED_SLOT_A_A     = 8'h08;  // Reserved slot, reads zero
  localparam logic [7:0] ADDR_RESERVED_SLOT_A_B     = 8'h09;  // Reserved slot, reads zero
  localparam logic [7:0] AUTOCLR_RESET   = 8'hFF;  // Mask value after reset
  localparam logic [7:0] AUTOCLR_RESERVED_SLOT_A    = 8'h04;  // Reserved mask bit, held at reset value
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;  // Read answer for unmapped addresses

  // ************************************************************
  // Auto-clear mask field positions
  // ************************************************************
  localparam int AUTOCLR_LINK_FAULT_BIT   = 7;
  localparam int AUTOCLR_THERMAL_SD_BIT   = 6;
  localparam int AUTOCLR_SUPPLY_UNDER_BIT = 5;
  localparam int AUTOCLR_SUPPLY_WARN_BIT  = 4;
  localparam int AUTOCLR_OVERCURRENT_BIT  = 3;
  localparam int AUTOCLR_RESERVED_BIT     = 2;
  localparam int AUTOCLR_THERMAL_CNS_BIT  = 1;
  localparam int AUTOCLR_OPEN_LOAD_BIT    = 0;

  // ************************************************************
  // Control byte layout
  // ************************************************************
  localparam int CTL_BROADCAST_BIT = 7;    // Broadcast write
  localparam int CTL_READ_BIT      = 6;    // 1 read, 0 write
  localparam int CTL_RESERVED_SLOT_A_BIT      = 5;    // Must be zero
  localparam int CID_W             = 5;    // Chain id width, bits 4..0 reversed
  localparam logic [CID_W-1:0] CID_SELF = 5'h00;  // Id of the addressed part

  // ************************************************************
  // Framing counts
  // ************************************************************
  localparam logic [3:0] BYTE_BITS   = 4'h8;  // Bits in one framed byte
  localparam logic [3:0] BIT_SAT     = 4'h9;  // Saturation of the bit counter
  localparam logic [3:0] CID_FIRST   = 4'h3;  // Bits taken before first id bit
  localparam int         TOK_W       = 9;     // Token: {resync marker, byte}
  localparam int         BUF_DEPTH   = 2;     // Entries in the token buffer

  // Packet sequencer states
  typedef enum logic [2:0] {
    SDST_PKT_CTRL = 3'b001,
    SDST_PKT_ADDR = 3'b010,
    SDST_PKT_DATA = 3'b100
  } sdst_pkt_t;

endpackage : sdst_pkg

// ---- hdl/sdst_pair_buf.sv ----
// Small token buffer with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module sdst_pair_buf #(
  parameter int W     = 9,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // Filling side
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  // Draining side
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;   // Entries
    logic [PW-1:0]           wp;    // Write pointer
    logic [PW-1:0]           rp;    // Read pointer
    logic [PW:0]             cnt;   // Occupancy
  } sdst_buf_st_t;

  sdst_buf_st_t st_r;
  sdst_buf_st_t st_nxt;
  logic         push;
  logic         pop;

  // Honest flags straight from the occupancy count
  assign inReady  = (st_r.cnt != FULL);
  assign outValid = (st_r.cnt != '0);
  assign outData  = st_r.mem[st_r.rp];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Next state: pointers wrap at DEPTH, not at a power of two
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = inData;
      st_nxt.wp = (st_r.wp == PW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == PW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : sdst_pair_buf

// ---- verification/sdst_spi_master.sv ----
// Behavioural serial master that frames each byte under its own select.
// Assumes the core clock times the bits: 4 clocks low, 4 high (320 ns).
`timescale 1ns/1ns
module sdst_spi_master (
  // Bit timer
  input  wire logic core_clk,
  // Pins towards the target
  output logic      sclkPin,
  output logic      selectN,
  output logic      mosiPin,
  // Answers from the target
  input  wire logic misoOut,
  input  wire logic misoOe,
  input  wire logic chainDataOut
);
  // ************************************************************
  // Resolved read line
  // ************************************************************
  logic lastMiso;  // Last bit the target drove; a released line shows its inverse
  logic misoLine;  // What the master really sees on the wire

  initial begin
    sclkPin  = 1'b0;
    selectN  = 1'b1;
    mosiPin  = 1'b0;
    lastMiso = 1'b0;
  end

  // Remember the driven bit so a stale value never passes as read data
  always @(posedge core_clk) begin
    if (misoOe) begin
      lastMiso <= misoOut;
    end
  end

  assign misoLine = misoOe ? misoOut : ~lastMiso;

  // ************************************************************
  // Tasks
  // ************************************************************
  // Step n clocks, then settle just after the edge
  task automatic waitClk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : waitClk

  // One framed byte of nBits clocks, MSB first; samples the answers late in each bit
  task automatic xfer(input logic [7:0] tx, input int nBits, output logic [7:0] rx,
                      output logic [7:0] thru, output logic oeSeen);
    rx     = 8'h00;
    thru   = 8'h00;
    oeSeen = 1'b0;
    waitClk(1);
    selectN = 1'b0;  // Each byte framed on its own
    waitClk(4);
    for (int i = 0; i < nBits; i++) begin
      mosiPin = tx[(7-i) & 7];  // A ninth bit repeats the MSB
      waitClk(4);
      sclkPin = 1'b1;
      waitClk(4);
      rx      = {rx[6:0], misoLine};
      thru    = {thru[6:0], chainDataOut};
      oeSeen  = oeSeen | misoOe;
      sclkPin = 1'b0;
    end
    waitClk(4);
    oeSeen  = oeSeen | misoOe;
    selectN = 1'b1;
    mosiPin = ~mosiPin;  // Released data line carries no stale value
    waitClk(10);         // Gap lets the address decode before a data byte
  endtask : xfer

  // Realign: one clock pulse with select high
  task automatic resync();
    waitClk(4);
    sclkPin = 1'b1;
    waitClk(4);
    sclkPin = 1'b0;
    waitClk(10);
  endtask : resync
endmodule : sdst_spi_master

// ---- verification/tb_sdst_spi_target.sv ----
// Self-checking bench for the serial target: table of packets, then hand tests.
// Assumes the master model above and a 25 MHz core clock.
`timescale 1ns/1ns
module tb_sdst_spi_target;
  // ************************************************************
  // Signals
  // ************************************************************
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] expMask;
    logic [7:0] expRd;
  } sdst_row_t;

  logic       core_clk;       // Core clock
  logic       reset;          // Async reset
  logic       sclkPin;        // Serial clock
  logic       selectN;        // Byte select, active low
  logic       mosiPin;        // Serial data in
  logic       misoOut;        // Read data
  logic       misoOe;         // Read data enable
  logic       chainDataOut;   // Pass-through
  logic [7:0] autoClearMask;  // Mask register
  int         failCount;      // Mismatches
  int         checked;        // Comparisons
  logic [7:0] rdB [3];        // Read bits per byte
  logic [7:0] thruB [3];      // Pass-through per byte
  logic       oeB [3];        // Enable seen per byte

  // Single-part packets use id zero, except rows with control 08, 88 and 50, which carry a nonzero id
  sdst_row_t rows [12] = '{
    '{8'h40, 8'h07, 8'h00, 8'hFF, 8'hFF}, '{8'h00, 8'h07, 8'h5A, 8'h5E, 8'h00},
    '{8'h40, 8'h07, 8'h00, 8'h5E, 8'h5E}, '{8'h00, 8'h07, 8'h00, 8'h04, 8'h00},
    '{8'h08, 8'h07, 8'hFF, 8'h04, 8'h00}, '{8'h88, 8'h07, 8'hA3, 8'hA7, 8'h00},
    '{8'h00, 8'h08, 8'h11, 8'hA7, 8'h00}, '{8'h00, 8'h06, 8'h11, 8'hA7, 8'h00},
    '{8'h40, 8'h09, 8'h00, 8'hA7, 8'h00}, '{8'h40, 8'h08, 8'h00, 8'hA7, 8'h00},
    '{8'h50, 8'h07, 8'h00, 8'hA7, 8'h00}, '{8'hC0, 8'h07, 8'h00, 8'hA7, 8'hA7}
  };

  // ************************************************************
  // Instances
  // ************************************************************
  sdst_spi_target uut (
    .core_clk     (core_clk),
    .reset        (reset),
    .sclkPin      (sclkPin),
    .selectN      (selectN),
    .mosiPin      (mosiPin),
    .misoOut      (misoOut),
    .misoOe       (misoOe),
    .chainDataOut (chainDataOut),
    .autoClearMask(autoClearMask)
  );

  sdst_spi_master mst (
    .core_clk    (core_clk),
    .sclkPin     (sclkPin),
    .selectN     (selectN),
    .mosiPin     (mosiPin),
    .misoOut     (misoOut),
    .misoOe      (misoOe),
    .chainDataOut(chainDataOut)
  );

  // Free-running core clock
  always #20 core_clk = ~core_clk;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Compare and count; four-state equality so unknowns fail
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Id field is bit-reversed, so the decrement is done on the unreversed value
  function automatic logic [7:0] chainCtl(input logic [7:0] c);
    logic [4:0] id;
    id = {c[0], c[1], c[2], c[3], c[4]} - 5'h01;
    return {c[7:5], id[0], id[1], id[2], id[3], id[4]};
  endfunction : chainCtl

  // Three-byte packet; the data byte may be cut short
  task automatic doPkt(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d, input int n);
    mst.xfer(c, 8, rdB[0], thruB[0], oeB[0]);
    mst.xfer(a, 8, rdB[1], thruB[1], oeB[1]);
    mst.xfer(d, n, rdB[2], thruB[2], oeB[2]);
  endtask : doPkt

  // Verdict and end of run
  task automatic results();
    if (failCount == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // Watchdog: the whole run needs well under 300 us
  initial begin
    #1_000_000;
    failCount++;
    results();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    core_clk  = 1'b0;
    reset     = 1'b1;
    failCount = 0;
    checked   = 0;
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b0;
    mst.waitClk(5);
    check(autoClearMask, 8'hFF);
    check({7'h00, misoOe}, 8'h00);
    // Table of packets
    foreach (rows[k]) begin
      doPkt(rows[k].ctl, rows[k].addr, rows[k].data, 8);
      check(thruB[0], chainCtl(rows[k].ctl));
      check(thruB[1], rows[k].addr);
      check(thruB[2], rows[k].data);
      check({7'h00, oeB[0] | oeB[1]}, 8'h00);
      check({7'h00, oeB[2]}, {7'h00, rows[k].ctl[6] && rows[k].ctl[4:0] == 5'h00});
      if (oeB[2] === 1'b1) check(rdB[2], rows[k].expRd);
      check(autoClearMask, rows[k].expMask);
    end
    // Write cut off in its data byte, then realigned and reissued
    doPkt(8'h00, 8'h07, 8'hC3, 5);
    mst.resync();
    check(autoClearMask, 8'hA7);
    doPkt(8'h00, 8'h07, 8'hC3, 8);
    check(autoClearMask, 8'hC7);
    // Lone control byte, realign, then a clean read
    mst.xfer(8'h00, 8, rdB[0], thruB[0], oeB[0]);
    mst.resync();
    doPkt(8'h40, 8'h07, 8'h00, 8);
    check(rdB[2], 8'hC7);
    // A short byte is dropped without advancing the sequence
    mst.xfer(8'h00, 8, rdB[0], thruB[0], oeB[0]);
    mst.xfer(8'h07, 8, rdB[1], thruB[1], oeB[1]);
    mst.xfer(8'hFF, 3, rdB[2], thruB[2], oeB[2]);
    mst.xfer(8'h18, 8, rdB[2], thruB[2], oeB[2]);
    check(autoClearMask, 8'h1C);
    // Nine clocks in the data byte: the last eight bits taken form the byte
    doPkt(8'h00, 8'h07, 8'h81, 9);
    check(autoClearMask, 8'h07);
    // Reset in mid-run restores the mask
    reset = 1'b1;
    mst.waitClk(2);
    reset = 1'b0;
    mst.waitClk(5);
    check(autoClearMask, 8'hFF);
    doPkt(8'h40, 8'h07, 8'h00, 8);
    check(rdB[2], 8'hFF);
    results();
  end
endmodule : tb_sdst_spi_target
